// ===== rtl/bchc_pkg.sv
package bchc_pkg;

  // ----------------------------------------------------------------
  // Bus status encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] BCHC_STATUS_IDLE = 3'h7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       BCHC_FLAG_CLEAR  = 1'b0;
  localparam logic       BCHC_LINE_IDLE   = 1'b1;
  localparam logic [3:0] BCHC_PHASE_CLEAR = 4'h0;

  // ----------------------------------------------------------------
  // Phase shift register bit positions
  // ----------------------------------------------------------------
  localparam int BCHC_PH1 = 0;
  localparam int BCHC_PH2 = 1;
  localparam int BCHC_PH3 = 2;
  localparam int BCHC_PH4 = 3;

  // Counter states of one request/grant channel
  typedef enum logic [1:0] {
    BCHC_RG_IDLE,
    BCHC_RG_REQUESTED,
    BCHC_RG_ACKED
  } bchc_rg_state_t;

  // Status lines from the processor
  typedef struct packed {
    logic bus_status_line_c;
    logic bus_status_line_b;
    logic bus_status_line_a;
  } bchc_status_t;

  // Data enable internals
  typedef struct packed {
    logic write_data_enable_early;
    logic write_data_enable_late;
    logic read_data_enable;
  } bchc_den_t;

endpackage : bchc_pkg

// ===== rtl/bchc_rg_counter.sv
`timescale 1ns/100ps

// Three-pulse counter for one request/grant channel
module bchc_rg_counter
  import bchc_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic divider_clear_in,
  input  wire logic buffered_request_grant_in,
  input  wire logic min_mode_in,
  output logic      pending_grant_flag_out,
  output logic      hold_ack_flag_out,
  output logic      bus_hold_ack_out
);
  import bchc_pkg::*;

  bchc_rg_state_t state;
  bchc_rg_state_t next_state;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    // Low line during the sampled cycle is one counting pulse
    if (!buffered_request_grant_in) begin
      case (state)
        BCHC_RG_IDLE:      next_state = BCHC_RG_REQUESTED;
        BCHC_RG_REQUESTED: next_state = BCHC_RG_ACKED;
        BCHC_RG_ACKED:     next_state = BCHC_RG_IDLE;
        default:           next_state = BCHC_RG_IDLE;
      endcase
    end
  end

  // Divider clear is asynchronous on the counters
  always_ff @(posedge ref_clk_in or posedge divider_clear_in) begin
    if (divider_clear_in) begin
      state <= BCHC_RG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign pending_grant_flag_out = (state == BCHC_RG_REQUESTED);
  assign hold_ack_flag_out      = (state == BCHC_RG_ACKED);
  // Acknowledge to the system under test only in minimum mode
  assign bus_hold_ack_out       = hold_ack_flag_out & min_mode_in;

endmodule // bchc_rg_counter

// ===== rtl/bchc_core.sv
`timescale 1ns/100ps

// Operation
// - Any status line falling from all-high idle starts a new bus cycle, except into the halt pattern.
// - Address latch strobe rises one cycle before phase one.
// - Strobe drops in phase one and stays low while status is active.
// - Address is captured on the strobe's falling edge.
// - Halt status pattern clears phase one so no cycle runs.
// - Early write enable set with the strobe in phase one.
// - Late write enable set when phase one is sampled high.
// - Read enable set from late write enable when phase two is sampled high.
// - Active-low data enable picks early write or read by direction.
// - Data enable held until phase four, which clears the enables.
// - Divider clear forces both counter flags to zero.
// - Counter advances on each cycle its buffered line is low.
// - First pulse sets pending grant, acknowledge stays low.
// - Second pulse sets acknowledge; driven out only in minimum mode.
// - Third pulse clears both flags, ready for the next sequence.
// - Two identical counters, one for each request/grant line.
// - Maximum mode uses request/grant lines instead of hold pair.
// - Request is halt, or hold qualified by minimum mode, sampled.
// - New request drives the selected line low for one cycle.
// - A request held on later clocks makes no further pulses.
// - Withdrawn request gives a one-cycle low release pulse.
// - Four phases come from a shift register fed by the strobe.
// - Divider clear follows the active-high system reset.

module bchc_core
  import bchc_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire bchc_pkg::bchc_status_t status_in,
  input  wire logic              transfer_direction_in,
  input  wire logic [19:0]       address_in,
  input  wire logic              hold_request_in,
  input  wire logic              halt_request_in,
  input  wire logic              min_mode_in,
  input  wire logic              channel_select_in,
  input  wire logic              request_grant_line_zero_in,
  input  wire logic              request_grant_line_one_in,
  output logic                   request_grant_line_zero_out,
  output logic                   request_grant_line_zero_oe_out,
  output logic                   request_grant_line_one_out,
  output logic                   request_grant_line_one_oe_out,
  output logic                   addr_latch_strobe_out,
  output logic [19:0]            latched_address_out,
  output logic [3:0]             bus_phase_out,
  output logic                   data_enable_n_out,
  output logic                   hold_ack_chan_zero_out,
  output logic                   hold_ack_chan_one_out,
  output logic                   pending_grant_zero_out,
  output logic                   pending_grant_one_out,
  output logic                   bus_hold_ack_out
);
  import bchc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic status_is_idle(input bchc_status_t s);
    return ({s.bus_status_line_c, s.bus_status_line_b, s.bus_status_line_a}
            == BCHC_STATUS_IDLE);
  endfunction

  function automatic logic status_is_halt(input bchc_status_t s);
    return s.bus_status_line_a & s.bus_status_line_b & ~status_is_idle(s);
  endfunction

  // ----------------------------------------------------------------
  // Cycle start, strobe and phase shift register
  // ----------------------------------------------------------------
  logic       status_was_idle;
  logic       next_status_was_idle;
  logic       strobe;
  logic       next_strobe;
  logic [3:0] phase;
  logic [3:0] next_phase;
  logic [19:0] next_latched_address;
  logic       cycle_start;

  // Idle relies on the processor returning status high before phase four ends
  assign cycle_start = status_was_idle & ~status_is_idle(status_in);

  always_comb begin
    next_status_was_idle = status_is_idle(status_in);
    // One-cycle strobe per detected cycle; halt suppresses it
    next_strobe = cycle_start & ~status_is_halt(status_in);
    // Strobe walks through four phases
    next_phase = {phase[BCHC_PH3], phase[BCHC_PH2], phase[BCHC_PH1], strobe};
    if (status_is_halt(status_in)) begin
      next_phase[BCHC_PH1] = 1'b0;
    end
    next_latched_address = latched_address_out;
    // Capture as the strobe falls
    if (strobe && !next_strobe) begin
      next_latched_address = address_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_was_idle     <= 1'b1;
      strobe              <= 1'b0;
      phase               <= BCHC_PHASE_CLEAR;
      latched_address_out <= '0;
    end else begin
      status_was_idle     <= next_status_was_idle;
      strobe              <= next_strobe;
      phase               <= next_phase;
      latched_address_out <= next_latched_address;
    end
  end

  assign addr_latch_strobe_out = strobe;
  assign bus_phase_out         = phase;

  // ----------------------------------------------------------------
  // Data enable
  // ----------------------------------------------------------------
  bchc_den_t data_enable_out;
  bchc_den_t next_den;
  logic      next_data_enable_n;

  always_comb begin
    next_den = data_enable_out;
    // Phase four ends the enables; a set in the same cycle still wins
    if (phase[BCHC_PH4]) begin
      next_den = '0;
    end
    if (strobe) begin
      next_den.write_data_enable_early = 1'b1;
    end
    if (phase[BCHC_PH1]) begin
      next_den.write_data_enable_late = 1'b1;
    end
    if (phase[BCHC_PH2] && data_enable_out.write_data_enable_late) begin
      next_den.read_data_enable = 1'b1;
    end
    // Direction high selects write path
    next_data_enable_n = transfer_direction_in ? ~next_den.write_data_enable_early
                                               : ~next_den.read_data_enable;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_enable_out               <= '0;
      data_enable_n_out <= 1'b1;
    end else begin
      data_enable_out               <= next_den;
      data_enable_n_out <= next_data_enable_n;
    end
  end

  // ----------------------------------------------------------------
  // Request/grant pulse generator
  // ----------------------------------------------------------------
  logic req_raw;
  logic req_sampled;
  logic next_req_sampled;
  logic req_active;
  logic next_req_active;
  logic active_chan;
  logic next_active_chan;
  logic pulse_low;
  logic next_pulse_low;
  logic pulse_chan;
  logic next_pulse_chan;

  // Hold counts only in minimum mode; halt always
  assign req_raw = halt_request_in | (hold_request_in & min_mode_in);

  always_comb begin
    next_req_sampled = req_raw;
    next_req_active  = req_active;
    next_active_chan = active_chan;
    next_pulse_low   = 1'b0;
    next_pulse_chan  = pulse_chan;
    // Rising request while inactive gives one request pulse
    if (req_sampled && !req_active) begin
      next_req_active  = 1'b1;
      next_active_chan = channel_select_in;
      next_pulse_low   = 1'b1;
      next_pulse_chan  = channel_select_in;
    end else if (!req_sampled && req_active) begin
      // Withdrawal issues release on the same line
      next_req_active = 1'b0;
      next_pulse_low  = 1'b1;
      next_pulse_chan = active_chan;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_sampled <= 1'b0;
      req_active  <= 1'b0;
      active_chan <= 1'b0;
      pulse_low   <= 1'b0;
      pulse_chan  <= 1'b0;
    end else begin
      req_sampled <= next_req_sampled;
      req_active  <= next_req_active;
      active_chan <= next_active_chan;
      pulse_low   <= next_pulse_low;
      pulse_chan  <= next_pulse_chan;
    end
  end

  // Open-drain style: drive low only during the pulse
  assign request_grant_line_zero_out    = ~BCHC_LINE_IDLE;
  assign request_grant_line_one_out     = ~BCHC_LINE_IDLE;
  assign request_grant_line_zero_oe_out = pulse_low & ~pulse_chan;
  assign request_grant_line_one_oe_out  = pulse_low & pulse_chan;

  // ----------------------------------------------------------------
  // Counters; buffered line sees our pulse and the processor grant
  // ----------------------------------------------------------------
  logic divider_clear;
  logic buffered_request_grant_zero;
  logic buffered_request_grant_one;
  logic ack_zero;
  logic ack_one;

  assign divider_clear = rst_in;
  // Grant from the processor arrives as a one-cycle low
  assign buffered_request_grant_zero = request_grant_line_zero_in
                                       & ~request_grant_line_zero_oe_out;
  assign buffered_request_grant_one  = request_grant_line_one_in
                                       & ~request_grant_line_one_oe_out;

  // Two identical channels
  bchc_rg_counter u_chan_zero (
    .ref_clk_in                (ref_clk_in),
    .divider_clear_in          (divider_clear),
    .buffered_request_grant_in (buffered_request_grant_zero),
    .min_mode_in               (min_mode_in),
    .pending_grant_flag_out    (pending_grant_zero_out),
    .hold_ack_flag_out         (hold_ack_chan_zero_out),
    .bus_hold_ack_out          (ack_zero)
  );

  bchc_rg_counter u_chan_one (
    .ref_clk_in                (ref_clk_in),
    .divider_clear_in          (divider_clear),
    .buffered_request_grant_in (buffered_request_grant_one),
    .min_mode_in               (min_mode_in),
    .pending_grant_flag_out    (pending_grant_one_out),
    .hold_ack_flag_out         (hold_ack_chan_one_out),
    .bus_hold_ack_out          (ack_one)
  );

  assign bus_hold_ack_out = ack_zero | ack_one;

endmodule // bchc_core

// ===== test/bchc_core_props.sv
`timescale 1ns/100ps

module bchc_core_props
  import bchc_pkg::*;
(
  input wire logic         ref_clk_in,
  input wire logic         rst_in,
  input wire bchc_status_t status_in,
  input wire logic [19:0]  address_in,
  input wire logic         min_mode_in,
  input wire logic         request_grant_line_zero_oe_out,
  input wire logic         addr_latch_strobe_out,
  input wire logic [19:0]  latched_address_out,
  input wire logic [3:0]   bus_phase_out,
  input wire logic         data_enable_n_out,
  input wire logic         hold_ack_chan_zero_out,
  input wire logic         hold_ack_chan_one_out,
  input wire logic         pending_grant_zero_out,
  input wire logic         bus_hold_ack_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------
  // Bus cycle
  // ----------------------------------------------------------------
  sequence s_new_cycle;
    $past(status_in) == BCHC_STATUS_IDLE && status_in != BCHC_STATUS_IDLE && status_in != 3'h3;
  endsequence
  sequence s_later_phases;
    bus_phase_out[1] ##1 bus_phase_out[2] ##1 bus_phase_out[3];
  endsequence

  a_strobe_start: assert property (s_new_cycle |=> addr_latch_strobe_out)
    else $error("strobe missing after cycle start");
  a_strobe_drop: assert property (addr_latch_strobe_out |=> !addr_latch_strobe_out)
    else $error("strobe longer than one cycle");
  a_phase_one: assert property (addr_latch_strobe_out |=> bus_phase_out[0])
    else $error("phase one does not follow strobe");
  a_phase_chain: assert property (bus_phase_out[0] |=> s_later_phases)
    else $error("phase chain broken");
  a_addr_latch: assert property ($fell(addr_latch_strobe_out) |=>
    latched_address_out == address_in)
    else $error("address not latched");
  a_halt_phase: assert property ($past(status_in) == BCHC_STATUS_IDLE && status_in == 3'h3
    |=> !bus_phase_out[0] [*3])
    else $error("halt produced phase one");
  a_den_active: assert property (bus_phase_out[2] |-> !data_enable_n_out)
    else $error("data enable not low in phase three");
  a_den_release: assert property (bus_phase_out[3] |-> ##[1:2] data_enable_n_out)
    else $error("data enable not released after phase four");

  // ----------------------------------------------------------------
  // Request and grant
  // ----------------------------------------------------------------
  a_req_single: assert property (request_grant_line_zero_oe_out
    |=> !request_grant_line_zero_oe_out)
    else $error("request pulse longer than one cycle");
  a_flags_apart: assert property (!(pending_grant_zero_out && hold_ack_chan_zero_out))
    else $error("pending and acknowledge both set");
  a_ack_gate: assert property (bus_hold_ack_out ==
    (min_mode_in && (hold_ack_chan_zero_out || hold_ack_chan_one_out)))
    else $error("hold acknowledge gating wrong");
endmodule // bchc_core_props

// ===== test/bchc_cpu_model.sv
`timescale 1ns/100ps

// Processor side of both request/grant lines: grants each request after
// a settable delay, so prompt and slow answers can both be exercised
module bchc_cpu_model (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic [1:0] pin_in,
  input  wire logic [3:0] delay_in,
  output logic      [1:0] drive_out
);
  logic [1:0] waiting;
  logic [1:0] granted;
  logic [3:0] cnt [2];

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_out <= 2'h0;
      waiting   <= 2'h0;
      granted   <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        drive_out[c] <= 1'b0;
        if (waiting[c]) begin
          if (cnt[c] == 4'h0) begin
            drive_out[c] <= 1'b1;
            waiting[c]   <= 1'b0;
          end else begin
            cnt[c] <= cnt[c] - 4'h1;
          end
        end else if (!pin_in[c] && !drive_out[c]) begin
          // A low we did not make is a request, or else the release
          granted[c] <= !granted[c];
          if (!granted[c]) begin
            waiting[c] <= 1'b1;
            cnt[c]     <= delay_in;
          end
        end
      end
    end
  end
endmodule // bchc_cpu_model

// ===== test/bchc_core_test.sv
`timescale 1ns/100ps

module bchc_core_test;
  import bchc_pkg::*;
  logic ref_clk_in, rst_in, dir, hold, halt, minm, chsel;
  bchc_status_t st;
  logic [19:0] adr, lat;
  logic [3:0] ph, dly;
  logic [1:0] drv, oe, pin, ack, pend, rgo;
  logic strobe, den_n, bha;
  int errors, n_tests, cyc, lows [2];

  // Open-drain lines with pull-up: low while either party drives a low
  assign pin = ~(drv | (oe & ~rgo));

  bchc_core dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .status_in(st),
    .transfer_direction_in(dir), .address_in(adr), .hold_request_in(hold),
    .halt_request_in(halt), .min_mode_in(minm), .channel_select_in(chsel),
    .request_grant_line_zero_in(pin[0]), .request_grant_line_one_in(pin[1]),
    .request_grant_line_zero_out(rgo[0]), .request_grant_line_zero_oe_out(oe[0]),
    .request_grant_line_one_out(rgo[1]), .request_grant_line_one_oe_out(oe[1]),
    .addr_latch_strobe_out(strobe), .latched_address_out(lat), .bus_phase_out(ph),
    .data_enable_n_out(den_n), .hold_ack_chan_zero_out(ack[0]),
    .hold_ack_chan_one_out(ack[1]), .pending_grant_zero_out(pend[0]),
    .pending_grant_one_out(pend[1]), .bus_hold_ack_out(bha));
  bchc_cpu_model cpu (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .pin_in(pin),
    .delay_in(dly), .drive_out(drv));

  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    cyc++;
    for (int c = 0; c < 2; c++) if (!pin[c]) lows[c]++;
    if (cyc > 3000) begin
      errors++;
      give_verdict;
    end
  end

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_cycle(input logic d, input bchc_status_t s, input logic [19:0] a);
    int n;
    n = 0;
    dir = d;
    adr = a;
    st = s;
    while (strobe !== 1'b1 && n < 4) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk(strobe, 1'b1);
    @(negedge ref_clk_in);
    chk({strobe, ph[0]}, 2'h1);
    chk(lat, a);
    @(negedge ref_clk_in);
    chk(den_n, !d);
    @(negedge ref_clk_in);
    chk(den_n, 1'b0);
    st = BCHC_STATUS_IDLE;
    repeat (3) @(negedge ref_clk_in);
    chk(den_n, 1'b1);
  endtask

  task automatic halt_cycle;
    logic seen;
    seen = 1'b0;
    st = 3'h3;
    repeat (5) begin
      @(negedge ref_clk_in);
      seen = seen | ph[0];
    end
    chk(seen, 1'b0);
    st = BCHC_STATUS_IDLE;
    repeat (2) @(negedge ref_clk_in);
  endtask

  task automatic hold_seq(input int c, input logic mm, input logic [3:0] d);
    int n, base;
    base = lows[c];
    n = 0;
    dly = d;
    chsel = c[0];
    minm = mm;
    if (mm) hold = 1'b1;
    else halt = 1'b1;
    while (lows[c] < base + 1 && n < 8) begin
      @(negedge ref_clk_in);
      n++;
    end
    repeat (2) @(negedge ref_clk_in);
    chk({pend[c], ack[c]}, 2'h2);
    repeat (d + 4) @(negedge ref_clk_in);
    chk({pend[c], ack[c], bha}, {2'h1, mm});
    // Other channel selected while active: release must stay on this line
    chsel = ~c[0];
    repeat (6) @(negedge ref_clk_in);
    chk(lows[c] - base, 2);
    hold = 1'b0;
    halt = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    chk(lows[c] - base, 3);
    chk({pend[c], ack[c], bha}, 3'h0);
  endtask

  task automatic give_verdict;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    {rst_in, dir, hold, halt, minm, chsel} = 6'h20;
    st = BCHC_STATUS_IDLE;
    adr = 20'h0;
    dly = 4'h0;
    repeat (6) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk({pend, ack, den_n, strobe}, 6'h2);
    rst_in = 1'b0;
    @(negedge ref_clk_in);
    bus_cycle(1'b1, 3'h6, 20'ha_5c3c);
    bus_cycle(1'b0, 3'h5, 20'h3_c5a5);
    halt_cycle;
    hold_seq(0, 1'b1, 4'h6);
    hold_seq(1, 1'b0, 4'h1);
    give_verdict;
  end
endmodule // bchc_core_test

bind bchc_core bchc_core_props u_props (.ref_clk_in, .rst_in, .status_in, .address_in,
  .min_mode_in, .request_grant_line_zero_oe_out, .addr_latch_strobe_out,
  .latched_address_out, .bus_phase_out, .data_enable_n_out, .hold_ack_chan_zero_out,
  .hold_ack_chan_one_out, .pending_grant_zero_out, .bus_hold_ack_out);
